// ===== src/sync_requant_pkg.sv
// Constants for the sync and requantizer control bank.
// How it works
// - No sync action unless master enable set.
// - Pulses pass only with bits 1 and 0.
// - Next-sync-only aligns first pulse, ignores later.
// - In next-sync-only mode, hardware clears divider sync enable after aligning.
// - Mode field 000 is 22%, 001 33%.
// - Requantizer active only while enable bit high.
// - Six-bit tuning word, 57 or 34 values.
// - Each tuning step moves band 0.5%.
package sync_requant_pkg;
  // Offsets are register indices; the byte address is four times the index.
  localparam logic [7:0] SYNC_CTRL_INDEX = 8'h3A;
  localparam logic [7:0] REQ_CTRL_INDEX = 8'h3C;
  localparam logic [7:0] TUNE_INDEX = 8'h3E;
  localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
  localparam logic [7:0] REQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] TUNE_RESET = 8'h1C;
  localparam int MASTER_BIT = 0;
  localparam int GATE_BIT = 1;
  localparam int NEXT_ONLY_BIT = 2;
  localparam int SYNC_MSB = 2;
  localparam int REQ_EN_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;
  localparam int TUNE_MSB = 5;
  localparam logic [2:0] MODE_22 = 3'h0;
  localparam logic [2:0] MODE_33 = 3'h1;
  // Number of legal tuning words per mode (57 and 34).
  localparam logic [6:0] TUNE_COUNT_22 = 7'h39;
  localparam logic [6:0] TUNE_COUNT_33 = 7'h22;
  // One tuning step in tenths of a percent of the sample rate (0.5%).
  localparam logic [8:0] TUNE_STEP_PERMILLE = 9'h005;

  // Highest legal tuning word for the selected bandwidth.
  function automatic logic [5:0] tune_limit(input logic wide);
    logic [6:0] cnt;
    cnt = wide ? TUNE_COUNT_33 : TUNE_COUNT_22;
    return 6'(cnt - 7'h01);
  endfunction
endpackage

// ===== src/clock_divider.sv
// Integer clock divider producing a one-cycle tick, restartable by sync.
`timescale 1ns/100ps
module clock_divider #(
  parameter int unsigned DIV_RATIO = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic restart,
  output logic tick_reg
);
  localparam logic [3:0] LAST = 4'(DIV_RATIO - 1);

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic tick_next;

  // A restart zeroes the count and ticks at once, so the output phase follows the pulse.
  always_comb begin
    cnt_next = cnt_reg + 4'h1;
    tick_next = 1'b0;
    if (restart) begin
      cnt_next = 4'h0;
      tick_next = 1'b1;
    end else if (cnt_reg == LAST) begin
      cnt_next = 4'h0;
      tick_next = 1'b1;
    end
  end

  // Counter and tick registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end
endmodule

// ===== src/sync_requant_ctrl.sv
// AHB-Lite control bank for divider sync and the noise shaping requantizer.
`timescale 1ns/100ps
module sync_requant_ctrl #(
  parameter int unsigned DIV_RATIO = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sync_in,
  output logic sync_buffer_enable,
  output logic divider_tick,
  output logic sync_aligned,
  output logic requantizer_enable,
  output logic [2:0] requantizer_mode,
  output logic requantizer_wide_band,
  output logic [5:0] requantizer_tuning,
  output logic [8:0] band_edge_permille
);
  logic [7:0] sync_reg;
  logic [7:0] sync_next;
  logic [7:0] rq_reg;
  logic [7:0] rq_next;
  logic [7:0] tune_reg;
  logic [7:0] tune_next;
  logic wr_valid_reg;
  logic wr_valid_next;
  logic [7:0] wr_index_reg;
  logic [7:0] wr_index_next;
  logic [31:0] hrdata_next;
  logic aligned_next;
  logic wide_next;
  logic [5:0] tune_eff_next;
  logic [8:0] band_next;
  logic addr_ok;
  logic ap_hit;
  logic [7:0] ap_index;
  logic wr_sync;
  logic wr_rq;
  logic wr_tune;
  logic accepted;
  logic [7:0] rd_byte;

  // Address phase decode; only word-aligned addresses in the low kilobyte map.
  assign addr_ok = hsel && htrans[1] && hready;
  assign ap_index = haddr[9:2];
  assign ap_hit = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
  assign wr_sync = wr_valid_reg && (wr_index_reg == sync_requant_pkg::SYNC_CTRL_INDEX);
  assign wr_rq = wr_valid_reg && (wr_index_reg == sync_requant_pkg::REQ_CTRL_INDEX);
  assign wr_tune = wr_valid_reg && (wr_index_reg == sync_requant_pkg::TUNE_INDEX);

  // A pulse reaches the divider only with both the master buffer and the gate on.
  assign accepted = sync_in && sync_reg[sync_requant_pkg::MASTER_BIT]
                    && sync_reg[sync_requant_pkg::GATE_BIT];

  // Next register values; bus writes land in the data phase.
  always_comb begin
    wr_valid_next = addr_ok && hwrite && ap_hit;
    wr_index_next = addr_ok ? ap_index : wr_index_reg;
    sync_next = sync_reg;
    rq_next = rq_reg;
    tune_next = tune_reg;
    if (wr_sync) begin
      sync_next = {5'h00, hwdata[sync_requant_pkg::SYNC_MSB:0]};
    end else if (accepted && sync_reg[sync_requant_pkg::NEXT_ONLY_BIT]) begin
      // A software rewrite in the same cycle wins, so a re-arm is never lost.
      sync_next[sync_requant_pkg::GATE_BIT] = 1'b0;
    end
    if (wr_rq) begin
      rq_next = {4'h0, hwdata[sync_requant_pkg::MODE_MSB:0]};
    end
    if (wr_tune) begin
      tune_next = {2'h0, hwdata[sync_requant_pkg::TUNE_MSB:0]};
    end
  end

  // Read mux uses next values so a read right after a write sees the new data.
  always_comb begin
    unique case (ap_index)
      sync_requant_pkg::SYNC_CTRL_INDEX: rd_byte = sync_next;
      sync_requant_pkg::REQ_CTRL_INDEX: rd_byte = rq_next;
      sync_requant_pkg::TUNE_INDEX: rd_byte = tune_next;
      default: rd_byte = 8'h00;
    endcase
    hrdata_next = hrdata;
    if (addr_ok && !hwrite) begin
      hrdata_next = ap_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Derived requantizer settings; codes other than 33% run the narrow band.
  always_comb begin
    wide_next = (rq_next[sync_requant_pkg::MODE_MSB:sync_requant_pkg::MODE_LSB]
                 == sync_requant_pkg::MODE_33);
    tune_eff_next = tune_next[sync_requant_pkg::TUNE_MSB:0];
    // Out of range words are clamped rather than wrapped, to keep the band inside Nyquist.
    if (tune_eff_next > sync_requant_pkg::tune_limit(wide_next)) begin
      tune_eff_next = sync_requant_pkg::tune_limit(wide_next);
    end
    band_next = 9'({3'h0, tune_eff_next} * sync_requant_pkg::TUNE_STEP_PERMILLE);
    aligned_next = accepted;
  end

  // All local state and every output register except the divider tick.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_reg <= sync_requant_pkg::SYNC_CTRL_RESET;
      rq_reg <= sync_requant_pkg::REQ_CTRL_RESET;
      tune_reg <= sync_requant_pkg::TUNE_RESET;
      wr_valid_reg <= 1'b0;
      wr_index_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      sync_buffer_enable <= 1'b0;
      sync_aligned <= 1'b0;
      requantizer_enable <= 1'b0;
      requantizer_mode <= 3'h0;
      requantizer_wide_band <= 1'b0;
      requantizer_tuning <= 6'h00;
      band_edge_permille <= 9'h000;
    end else begin
      sync_reg <= sync_next;
      rq_reg <= rq_next;
      tune_reg <= tune_next;
      wr_valid_reg <= wr_valid_next;
      wr_index_reg <= wr_index_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'b1; // Zero wait states, always OKAY.
      hresp <= 1'b0;
      sync_buffer_enable <= sync_next[sync_requant_pkg::MASTER_BIT];
      sync_aligned <= aligned_next;
      requantizer_enable <= rq_next[sync_requant_pkg::REQ_EN_BIT];
      requantizer_mode <= rq_next[sync_requant_pkg::MODE_MSB:sync_requant_pkg::MODE_LSB];
      requantizer_wide_band <= wide_next;
      requantizer_tuning <= tune_eff_next;
      band_edge_permille <= band_next;
    end
  end

  // The divider restarts on the same edge that records the alignment.
  clock_divider #(
    .DIV_RATIO(DIV_RATIO)
  ) u_divider (
    .mclk(mclk),
    .srst(srst),
    .restart(accepted),
    .tick_reg(divider_tick)
  );

  // Checks next to the logic; all share the one clock and reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_MASTER_OFF_NO_SYNC: assert property (
    !sync_reg[sync_requant_pkg::MASTER_BIT] |=> !sync_aligned)
    else $error("Sync aligned while master enable was off.");

  AST_GATE_PASSES: assert property (
    sync_in && sync_reg[0] && sync_reg[1] |=> sync_aligned)
    else $error("Gated pulse not passed to divider.");

  AST_NEXT_ONLY_IGNORES: assert property (
    accepted && sync_reg[sync_requant_pkg::NEXT_ONLY_BIT] && !wr_sync
    ##1 !wr_sync |-> !accepted)
    else $error("Later pulse accepted in next-sync-only mode.");

  AST_GATE_SELF_CLEAR: assert property (
    accepted && sync_reg[sync_requant_pkg::NEXT_ONLY_BIT] && !wr_sync
    |=> !sync_reg[sync_requant_pkg::GATE_BIT])
    else $error("Divider sync enable not cleared after alignment.");

  AST_MODE_SELECT: assert property (
    wr_rq |=> requantizer_wide_band == ($past(hwdata[3:1]) == 3'h1))
    else $error("Bandwidth mode does not follow the written field.");

  // A second write right behind the first may legally move the enable again.
  AST_ENABLE_FOLLOWS: assert property (
    wr_rq |=> requantizer_enable == $past(hwdata[0])
    ##1 ($stable(requantizer_enable) || $past(wr_rq)))
    else $error("Requantizer enable does not follow its bit.");

  // Any code but 001 must fall back to the narrow band.
  AST_WIDE_ONLY_CODE_ONE: assert property (
    requantizer_wide_band |-> requantizer_mode == sync_requant_pkg::MODE_33)
    else $error("Wide band selected by a code other than 001.");

  AST_TUNE_RANGE: assert property (
    requantizer_tuning <= (requantizer_wide_band ? 6'h21 : 6'h38))
    else $error("Tuning word outside the legal range.");

  AST_TUNE_STEP: assert property (
    $changed(requantizer_tuning) && requantizer_tuning == $past(requantizer_tuning) + 6'h01
    |-> band_edge_permille == $past(band_edge_permille) + 9'h005)
    else $error("Tuning step is not half a percent.");

  AST_RESERVED_ZERO: assert property (
    addr_ok && !hwrite |=> hrdata[31:8] == 24'h00_0000 && (sync_reg[7:3] == 5'h00)
    && (rq_reg[7:4] == 4'h0) && (tune_reg[7:6] == 2'h0))
    else $error("Reserved bits are not zero.");

  AST_RESTART_PHASE: assert property (
    accepted |=> divider_tick && sync_aligned)
    else $error("Divider did not restart on accepted pulse.");

  // An alignment may only follow a pulse that met both the buffer and the gate.
  AST_ALIGN_NEEDS_GATE: assert property (
    sync_aligned |-> $past(sync_in && sync_reg[sync_requant_pkg::MASTER_BIT]
    && sync_reg[sync_requant_pkg::GATE_BIT]))
    else $error("Alignment without a gated pulse.");

  // The buffer enable pin must track the stored master bit at all times.
  AST_BUFFER_MIRROR: assert property (
    sync_buffer_enable == sync_reg[sync_requant_pkg::MASTER_BIT])
    else $error("Sync buffer enable differs from the master bit.");

  // Main scenarios worth seeing in a run.

  COV_CONTINUOUS: cover property (accepted && !sync_reg[2] ##1 accepted);
  COV_NEXT_ONLY: cover property (accepted && sync_reg[2]);
  COV_WIDE_ON: cover property (requantizer_enable && requantizer_wide_band);
  COV_CLAMP: cover property (wr_tune && hwdata[5:0] == 6'h3F);
  COV_TUNE_STEP: cover property ($changed(requantizer_tuning) ##0
    requantizer_tuning == $past(requantizer_tuning) + 6'h01);
endmodule

// ===== testbench/tb_sync_requant_ctrl.sv
// Self-checking bench for the sync and requantizer control bank.
`timescale 1ns/100ps
module tb_sync_requant_ctrl;
  localparam int unsigned DIV = 5;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sync_in = 1'b0;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sync_buffer_enable;
  logic divider_tick;
  logic sync_aligned;
  logic requantizer_enable;
  logic [2:0] requantizer_mode;
  logic requantizer_wide_band;
  logic [5:0] requantizer_tuning;
  logic [8:0] band_edge_permille;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_al;
  logic [31:0] rd;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  sync_requant_ctrl #(.DIV_RATIO(DIV)) sync_requant_ctrl_i (.mclk(mclk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sync_in(sync_in), .sync_buffer_enable(sync_buffer_enable), .divider_tick(divider_tick),
    .sync_aligned(sync_aligned), .requantizer_enable(requantizer_enable),
    .requantizer_mode(requantizer_mode), .requantizer_wide_band(requantizer_wide_band),
    .requantizer_tuning(requantizer_tuning), .band_edge_permille(band_edge_permille));

  // Clock of 50 MHz.
  always #10 mclk = ~mclk;

  // A hang is cut short well after the whole sequence should be done.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; the wait is bounded only by the timeout.
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
    chk(hresp, 32'h0000_0000);
    @(negedge mclk);
  endtask

  // Drives a pulse of n high cycles and counts alignment pulses around it.
  task automatic pulse(input int n, output int c);
    c = 0;
    @(posedge mclk);
    sync_in <= 1'b1;
    for (int i = 0; i < n + 4; i++) begin
      @(negedge mclk);
      if (sync_aligned === 1'b1) c++;
      @(posedge mclk);
      if (i == n - 1) sync_in <= 1'b0;
    end
  endtask

  // Reset values and reserved bits, plus an unmapped place.
  task automatic t_regs();
    chk(requantizer_tuning, 32'h0000_001C);
    chk(band_edge_permille, 32'h0000_008C);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    bus(sync_requant_pkg::REQ_CTRL_INDEX, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    bus(sync_requant_pkg::TUNE_INDEX, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_001C);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b1, 32'hFFFF_FFFF, rd);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_0007);
    bus(sync_requant_pkg::REQ_CTRL_INDEX, 1'b1, 32'hFFFF_FFFF, rd);
    bus(sync_requant_pkg::REQ_CTRL_INDEX, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_000F);
    chk(requantizer_wide_band, 32'h0000_0000);
    bus(8'h3B, 1'b1, 32'hFFFF_FFFF, rd);
    bus(8'h3B, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_0000);
  endtask

  // Gating, continuous mode, next-sync-only and divider restart.
  task automatic t_sync();
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b1, 32'h0000_0002, rd);
    pulse(2, n_al);
    chk(n_al, 32'h0000_0000);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b1, 32'h0000_0001, rd);
    chk(sync_buffer_enable, 32'h0000_0001);
    pulse(2, n_al);
    chk(n_al, 32'h0000_0000);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b1, 32'h0000_0003, rd);
    pulse(2, n_al);
    chk(n_al, 32'h0000_0002);
    // Restart: tick right after the accepting edge, then DIV cycles later.
    pulse(1, n_al);
    chk(n_al, 32'h0000_0001);
    @(posedge mclk);
    sync_in <= 1'b1;
    @(posedge mclk);
    sync_in <= 1'b0;
    @(negedge mclk);
    chk({sync_aligned, divider_tick}, 32'h0000_0003);
    n_al = 0;
    repeat (DIV - 1) begin
      @(negedge mclk);
      if (divider_tick !== 1'b0) n_al++;
    end
    chk(n_al, 32'h0000_0000);
    @(negedge mclk);
    chk(divider_tick, 32'h0000_0001);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b1, 32'h0000_0007, rd);
    pulse(2, n_al);
    chk(n_al, 32'h0000_0001);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b0, 32'h0, rd);
    chk(rd, 32'h0000_0005);
    bus(sync_requant_pkg::SYNC_CTRL_INDEX, 1'b1, 32'h0000_0000, rd);
    chk(sync_buffer_enable, 32'h0000_0000);
  endtask

  // Mode, enable, tuning limits and band step.
  task automatic t_requant();
    bus(sync_requant_pkg::REQ_CTRL_INDEX, 1'b1, 32'h0000_0003, rd);
    chk({requantizer_enable, requantizer_mode, requantizer_wide_band}, 32'h0000_0013);
    bus(sync_requant_pkg::TUNE_INDEX, 1'b1, 32'h0000_0028, rd);
    chk(requantizer_tuning, 32'h0000_0021);
    chk(band_edge_permille, 32'h0000_00A5);
    bus(sync_requant_pkg::REQ_CTRL_INDEX, 1'b1, 32'h0000_0000, rd);
    chk({requantizer_enable, requantizer_wide_band}, 32'h0000_0000);
    chk(requantizer_tuning, 32'h0000_0028);
    bus(sync_requant_pkg::TUNE_INDEX, 1'b1, 32'h0000_0029, rd);
    chk(requantizer_tuning, 32'h0000_0029);
    chk(band_edge_permille, 32'h0000_00CD);
    bus(sync_requant_pkg::TUNE_INDEX, 1'b1, 32'h0000_0039, rd);
    chk(requantizer_tuning, 32'h0000_0038);
    chk(band_edge_permille, 32'h0000_0118);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    // Outputs leave their reset values only at the first edge after release.
    repeat (2) @(negedge mclk);
    t_regs();
    t_sync();
    t_requant();
    end_sim();
  end
endmodule
